/* design/vrtct_pkg.sv */
// Package: offsets, field positions, reset values and strap codes of the telemetry bank
package vrtct_pkg;
    // Register offsets
    localparam logic [7:0] OFS_PRIMARY_STATUS = 8'h10;
    localparam logic [7:0] OFS_ERROR_STATUS = 8'h11;
    localparam logic [7:0] OFS_TEMPERATURE_ZONE = 8'h12;
    localparam logic [7:0] OFS_ERROR_STATUS_LAST_READ = 8'h1C;
    localparam logic [7:0] OFS_MAX_CURRENT_CAPABILITY = 8'h21;
    localparam logic [7:0] OFS_MAX_TEMPERATURE = 8'h22;
    localparam logic [7:0] OFS_FAST_SLEW_CAPABILITY = 8'h24;
    localparam logic [7:0] OFS_SLOW_SLEW_CAPABILITY = 8'h25;
    // Primary status fields
    localparam int PST_SETTLED_BIT = 0;
    localparam int PST_THERM_ALERT_BIT = 1;
    localparam int PST_ICC_ALERT_BIT = 2;
    localparam int PST_ERR_PENDING_BIT = 7;
    // Error status fields
    localparam int EST_PARITY_BIT = 0;
    localparam int EST_FRAME_BIT = 1;
    // Temperature zone fields
    localparam int ZONE_ALERT_BIT = 6;
    localparam int ZONE_HOT_BIT = 7;
    // Reset and fixed values
    localparam logic [7:0] RST_BYTE = 8'h00;
    localparam logic [7:0] MAX_TEMPERATURE_VAL = 8'h64;
    // Current-limit strap levels
    localparam logic [4:0] CURRENT_LIMIT_STRAP_LEVEL_LOW_OFF = 5'h00;
    localparam logic [4:0] CURRENT_LIMIT_STRAP_LEVEL_HIGH_OFF = 5'h11;
    // Slew strap levels: 0 V, 1.5 V, 3 V, supply
    localparam logic [1:0] SR_LEVEL_0V = 2'h0;
    localparam logic [1:0] SR_LEVEL_1V5 = 2'h1;
    localparam logic [1:0] SR_LEVEL_3V = 2'h2;
    localparam logic [1:0] SR_LEVEL_VCC = 2'h3;
    localparam logic [7:0] FAST_SLEW_CAPABILITY_LO = 8'h0A;
    localparam logic [7:0] FAST_SLEW_CAPABILITY_HI = 8'h14;
    localparam logic [7:0] SLOW_SLEW_CAPABILITY_LO = 8'h02;
    localparam logic [7:0] SLOW_SLEW_CAPABILITY_HI = 8'h04;
endpackage

/* design/vrtct_current_limit_strap_lut.sv */
// Current-limit strap decode: per-phase report, latched-off detect, phase product
`timescale 1ns/1ps
`default_nettype none
module vrtct_current_limit_strap_lut #(
    parameter bit REG_B = 1'b0
) (
    // Strap level and phase count
    input wire logic [4:0] level,
    input wire logic [1:0] phases,
    // Decoded result
    output logic [7:0] icc_value,
    output logic level_off
);
    logic [7:0] per_phase;

    // Four-entry pattern repeats every four levels from level 1 upward
    always_comb begin
        level_off = (level <= vrtct_pkg::CURRENT_LIMIT_STRAP_LEVEL_LOW_OFF) ||
                    (level >= vrtct_pkg::CURRENT_LIMIT_STRAP_LEVEL_HIGH_OFF);
        unique case (2'((level - 5'h01) & 5'h03))
            2'h0: per_phase = 8'd35;
            2'h1: per_phase = 8'd33;
            2'h2: per_phase = REG_B ? 8'd22 : 8'd27;
            2'h3: per_phase = REG_B ? 8'd17 : 8'd22;
        endcase
        // Product fits 8 bits: at most 35 A times 3 phases
        icc_value = level_off ? 8'h00 : 8'(per_phase * {6'h00, phases});
    end
endmodule // vrtct_current_limit_strap_lut
`default_nettype wire

/* design/vrtct_hot.sv */
// Hot output driver fed straight from the thermal comparators
`timescale 1ns/1ps
`default_nettype none
module vrtct_hot (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Top comparators of both thermistors
    input wire logic hot_a,
    input wire logic hot_b,
    // Pin
    output logic hot_output_n
);
    logic hot_r;
    logic hot_nxt;

    // No bus state involved, so a stuck bus cannot mask throttling
    always_comb begin
        hot_nxt = hot_a | hot_b;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            hot_r <= 1'b0;
        end else begin
            hot_r <= hot_nxt;
        end
    end

    assign hot_output_n = ~hot_r;
endmodule // vrtct_hot
`default_nettype wire

/* design/vrtct_regs.sv */
// Telemetry and capability register bank with thermal alert and hot output
// What this block does
// - Temperature zone is an 8-bit thermometer code, 75 to 100 percent.
// - Exceeding 97 percent on either input sets thermal alert and alert line.
// - 100 percent bit on either regulator pulls hot output low.
// - Hot output comes straight from comparators, independent of the register path.
// - Offset 1Ch holds error status as captured by its last read.
// - Maximum temperature reads 64h, 100 degrees, at offset 22h.
// - Maximum current is per-phase limit times active phases, 1 A steps.
// - Strap level outside all thresholds disables that regulator.
// - Fast slew at 24h reads 0Ah or 14h per slew strap.
// - Slow slew at 25h reads 02h or 04h per slew strap, table coded.
// - Any change of primary status asserts the alert line.
// - Reading error status copies it to last-read, then clears it.
`timescale 1ns/1ps
`default_nettype none
module vrtct_regs (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Register access port
    input wire logic [7:0] reg_addr,
    input wire logic reg_rd,
    input wire logic reg_wr,
    input wire logic [7:0] reg_wdata,
    input wire logic reg_sel_b,
    output logic [7:0] reg_rdata,
    // Thermal comparators
    input wire logic [7:0] thermistor_input_a,
    input wire logic [7:0] thermistor_input_b,
    // Status sources
    input wire logic vr_settled,
    input wire logic icc_alert,
    input wire logic parity_err,
    input wire logic frame_err,
    // Straps
    input wire logic [4:0] current_limit_strap_a,
    input wire logic [4:0] current_limit_strap_b,
    input wire logic [1:0] active_phases_a,
    input wire logic [1:0] active_phases_b,
    input wire logic [1:0] slew_rate_strap,
    // Pins and controls
    output logic alert_n,
    output logic hot_output_n,
    output logic reg_a_disable,
    output logic reg_b_disable
);
    logic [7:0] zone_r;
    logic [7:0] zone_nxt;
    logic [7:0] prim_r;
    logic [7:0] prim_nxt;
    logic icc_latch_r;
    logic icc_latch_nxt;
    logic [7:0] err_r;
    logic [7:0] err_nxt;
    logic [7:0] last_r;
    logic [7:0] last_nxt;
    logic alert_r;
    logic alert_nxt;
    logic [7:0] rdata_r;
    logic [7:0] rdata_nxt;
    logic off_a_r;
    logic off_a_nxt;
    logic off_b_r;
    logic off_b_nxt;
    logic [7:0] icc_a;
    logic [7:0] icc_b;
    logic lvl_off_a;
    logic lvl_off_b;
    logic [7:0] fast_sr;
    logic [7:0] slow_sr;
    logic rd_prim;
    logic rd_err;
    logic [7:0] err_set;

    // Strap decode, one table per regulator
    vrtct_current_limit_strap_lut #(.REG_B(1'b0)) u_lut_a (
        .level(current_limit_strap_a),
        .phases(active_phases_a),
        .icc_value(icc_a),
        .level_off(lvl_off_a)
    );
    vrtct_current_limit_strap_lut #(.REG_B(1'b1)) u_lut_b (
        .level(current_limit_strap_b),
        .phases(active_phases_b),
        .icc_value(icc_b),
        .level_off(lvl_off_b)
    );

    // Hot output path bypasses every bus register
    vrtct_hot u_hot (
        .clock(clock),
        .arst_n(arst_n),
        .hot_a(thermistor_input_a[vrtct_pkg::ZONE_HOT_BIT]),
        .hot_b(thermistor_input_b[vrtct_pkg::ZONE_HOT_BIT]),
        .hot_output_n(hot_output_n)
    );

    // Slew strap decode; slow is table coded since its 04h entry is not 14h/4, which is 05h
    always_comb begin
        unique case (slew_rate_strap)
            vrtct_pkg::SR_LEVEL_0V,
            vrtct_pkg::SR_LEVEL_VCC: begin
                fast_sr = vrtct_pkg::FAST_SLEW_CAPABILITY_LO;
                slow_sr = vrtct_pkg::SLOW_SLEW_CAPABILITY_LO;
            end
            vrtct_pkg::SR_LEVEL_1V5,
            vrtct_pkg::SR_LEVEL_3V: begin
                fast_sr = vrtct_pkg::FAST_SLEW_CAPABILITY_HI;
                slow_sr = vrtct_pkg::SLOW_SLEW_CAPABILITY_HI;
            end
        endcase
    end

    // Read strobes; writes have no decode at all, so no bank register can change
    assign rd_prim = reg_rd && (reg_addr == vrtct_pkg::OFS_PRIMARY_STATUS);
    assign rd_err = reg_rd && (reg_addr == vrtct_pkg::OFS_ERROR_STATUS);

    // Error event bits
    always_comb begin
        err_set = 8'h00;
        err_set[vrtct_pkg::EST_PARITY_BIT] = parity_err;
        err_set[vrtct_pkg::EST_FRAME_BIT] = frame_err;
    end

    // Status state: zone, primary, error, last-read and alert
    always_comb begin
        zone_nxt = thermistor_input_a | thermistor_input_b;
        // ICC alert latches high; a primary status read reloads it
        icc_latch_nxt = rd_prim ? icc_alert : (icc_latch_r | icc_alert);
        prim_nxt = 8'h00;
        prim_nxt[vrtct_pkg::PST_SETTLED_BIT] = vr_settled;
        prim_nxt[vrtct_pkg::PST_THERM_ALERT_BIT] = zone_r[vrtct_pkg::ZONE_ALERT_BIT];
        prim_nxt[vrtct_pkg::PST_ICC_ALERT_BIT] = icc_latch_r;
        prim_nxt[vrtct_pkg::PST_ERR_PENDING_BIT] = |err_r;
        // Read copies then clears; a new error in the same cycle survives
        last_nxt = rd_err ? err_r : last_r;
        err_nxt = (rd_err ? 8'h00 : err_r) | err_set;
        // Alert stays low until status is polled; a change wins over the poll
        alert_nxt = (prim_nxt != prim_r) ? 1'b1 : (rd_prim ? 1'b0 : alert_r);
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            zone_r <= vrtct_pkg::RST_BYTE;
            prim_r <= vrtct_pkg::RST_BYTE;
            icc_latch_r <= 1'b0;
            err_r <= vrtct_pkg::RST_BYTE;
            last_r <= vrtct_pkg::RST_BYTE;
            alert_r <= 1'b0;
        end else begin
            zone_r <= zone_nxt;
            prim_r <= prim_nxt;
            icc_latch_r <= icc_latch_nxt;
            err_r <= err_nxt;
            last_r <= last_nxt;
            alert_r <= alert_nxt;
        end
    end

    assign alert_n = ~alert_r;

    // Regulator disable latches until reset, as a bad strap is a board fault
    always_comb begin
        off_a_nxt = off_a_r | lvl_off_a;
        off_b_nxt = off_b_r | lvl_off_b;
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            off_a_r <= 1'b0;
            off_b_r <= 1'b0;
        end else begin
            off_a_r <= off_a_nxt;
            off_b_r <= off_b_nxt;
        end
    end

    assign reg_a_disable = off_a_r;
    assign reg_b_disable = off_b_r;

    // Read mux; unmapped offsets read 00h, idle cycles hold the last answer
    always_comb begin
        rdata_nxt = rdata_r;
        if (reg_rd) begin
            unique case (reg_addr)
                vrtct_pkg::OFS_PRIMARY_STATUS: rdata_nxt = prim_r;
                vrtct_pkg::OFS_ERROR_STATUS: rdata_nxt = err_r;
                vrtct_pkg::OFS_TEMPERATURE_ZONE: rdata_nxt = zone_r;
                vrtct_pkg::OFS_ERROR_STATUS_LAST_READ: rdata_nxt = last_r;
                vrtct_pkg::OFS_MAX_CURRENT_CAPABILITY: begin
                    rdata_nxt = reg_sel_b ? icc_b : icc_a;
                end
                vrtct_pkg::OFS_MAX_TEMPERATURE: rdata_nxt = vrtct_pkg::MAX_TEMPERATURE_VAL;
                vrtct_pkg::OFS_FAST_SLEW_CAPABILITY: rdata_nxt = fast_sr;
                vrtct_pkg::OFS_SLOW_SLEW_CAPABILITY: rdata_nxt = slow_sr;
                default: rdata_nxt = vrtct_pkg::RST_BYTE;
            endcase
        end
    end

    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rdata_r <= vrtct_pkg::RST_BYTE;
        end else begin
            rdata_r <= rdata_nxt;
        end
    end

    assign reg_rdata = rdata_r;

    // Checks
    default clocking cb @(posedge clock); endclocking
    default disable iff (!arst_n);

    sequence s_err_read;
        rd_err && !parity_err && !frame_err;
    endsequence
    sequence s_copy_seen;
        last_r == $past(err_r) && err_r == 8'h00;
    endsequence

    property p_zone_code;
        1'b1 |=> zone_r == $past(thermistor_input_a | thermistor_input_b);
    endproperty
    a_zone_code: assert property (p_zone_code) else $error("zone code wrong");

    property p_therm_alert;
        (thermistor_input_a[6] || thermistor_input_b[6]) |=> zone_r[6] ##1 prim_r[1];
    endproperty
    a_therm_alert: assert property (p_therm_alert) else $error("thermal alert missed");

    // The alert bit coming up is itself a status change, so the line must drop with it
    sequence s_alert_bit_rises;
        $rose(zone_r[6]);
    endsequence
    property p_therm_alert_line;
        s_alert_bit_rises |=> prim_r[1] && !alert_n;
    endproperty
    a_therm_alert_line: assert property (p_therm_alert_line) else $error("alert line not driven");

    property p_hot_low;
        (thermistor_input_a[7] || thermistor_input_b[7]) |=> !hot_output_n;
    endproperty
    a_hot_low: assert property (p_hot_low) else $error("hot output not low");

    property p_hot_indep;
        (!thermistor_input_a[7] && !thermistor_input_b[7]) |=> hot_output_n;
    endproperty
    a_hot_indep: assert property (p_hot_indep) else $error("hot output stuck");

    property p_err_copy;
        s_err_read |=> s_copy_seen;
    endproperty
    a_err_copy: assert property (p_err_copy) else $error("last-read copy wrong");

    property p_err_set_wins;
        (rd_err && parity_err) |=> err_r[0];
    endproperty
    a_err_set_wins: assert property (p_err_set_wins) else $error("error lost on read");

    property p_max_temperature_threshold;
        (reg_rd && reg_addr == 8'h22) |=> reg_rdata == 8'h64;
    endproperty
    a_max_temperature_threshold: assert property (p_max_temperature_threshold) else $error("max temperature wrong");

    property p_icc;
        (reg_rd && reg_addr == 8'h21 && !reg_sel_b && !lvl_off_a) |=>
            reg_rdata == 8'($past(icc_a));
    endproperty
    a_icc: assert property (p_icc) else $error("max current wrong");

    property p_off;
        (current_limit_strap_a == 5'h00 || current_limit_strap_a == 5'h11) |=>
            reg_a_disable [*3];
    endproperty
    a_off: assert property (p_off) else $error("regulator not disabled");

    property p_slew;
        (reg_rd && reg_addr == 8'h24 && slew_rate_strap == 2'h0) |=> reg_rdata == 8'h0A;
    endproperty
    a_slew: assert property (p_slew) else $error("fast slew wrong");

    property p_slow;
        (reg_rd && reg_addr == 8'h25 && slew_rate_strap == 2'h2) |=> reg_rdata == 8'h04;
    endproperty
    a_slow: assert property (p_slow) else $error("slow slew wrong");

    property p_change_alert;
        (prim_r != $past(prim_r)) |-> !alert_n;
    endproperty
    a_change_alert: assert property (p_change_alert) else $error("alert not asserted");

    property p_write_ignored;
        (reg_wr && !reg_rd && !parity_err && !frame_err) |=>
            $stable(last_r) && $stable(err_r) && $stable(reg_rdata);
    endproperty
    a_write_ignored: assert property (p_write_ignored) else $error("write changed bank");

    property p_lut_off;
        current_limit_strap_b == 5'h11 |-> icc_b == 8'h00 && lvl_off_b;
    endproperty
    a_lut_off: assert property (p_lut_off) else $error("latched-off level decoded");
endmodule // vrtct_regs
`default_nettype wire

/* tb/vrtct_master.sv */
// Bus master model: turns bench read requests into one-cycle register reads
`timescale 1ns/1ps
`default_nettype none
module vrtct_master (
    // Clock and reset
    input wire logic clock,
    input wire logic arst_n,
    // Request from the bench
    input wire logic go,
    input wire logic [7:0] addr,
    // Register access side
    output logic reg_rd,
    output logic [7:0] reg_addr
);
    logic rd_r;
    logic rd_nxt;
    logic [7:0] addr_r;
    logic [7:0] addr_nxt;
    // Idle offset inverts each cycle, so the last live offset comes back on every second idle cycle
    always_comb begin
        rd_nxt = go;
        addr_nxt = go ? addr : ~addr_r;
    end
    // Request is launched on the edge and stands for one whole cycle
    always_ff @(posedge clock or negedge arst_n) begin
        if (!arst_n) begin
            rd_r <= 1'b0;
            addr_r <= 8'h00;
        end else begin
            rd_r <= rd_nxt;
            addr_r <= addr_nxt;
        end
    end
    assign reg_rd = rd_r;
    assign reg_addr = addr_r;
endmodule // vrtct_master
`default_nettype wire

/* tb/testbench.sv */
// Self-checking bench for the telemetry register bank
`timescale 1ns/1ps
`default_nettype none
module testbench;
    logic clock = 1'b0;
    logic arst_n = 1'b0;
    logic go = 1'b0;
    logic [7:0] addr = 8'h00;
    logic reg_rd;
    logic [7:0] reg_addr;
    logic reg_wr = 1'b0;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_sel_b = 1'b0;
    logic [7:0] reg_rdata;
    logic [7:0] therm_a = 8'h00;
    logic [7:0] therm_b = 8'h00;
    logic vr_settled = 1'b1;
    logic icc = 1'b0;
    logic [1:0] err_ev = 2'h0;
    logic [4:0] strap_a = 5'h01;
    logic [4:0] strap_b = 5'h01;
    logic [1:0] ph_a = 2'h1;
    logic [1:0] ph_b = 2'h1;
    logic [1:0] slew = 2'h0;
    logic alert_n, hot_output_n, reg_a_disable, reg_b_disable;
    int err_count = 0;
    int comparisons = 0;
    int cycles = 0;
    int lv, ph, k;
    logic pend = 1'b0;
    logic [7:0] exp_q[$];
    logic [7:0] tbl_a [4] = '{8'h23, 8'h21, 8'h1B, 8'h16};
    logic [7:0] tbl_b [4] = '{8'h23, 8'h21, 8'h16, 8'h11};

    always #2.5 clock = ~clock;

    vrtct_master vrtct_master_i (.clock(clock), .arst_n(arst_n), .go(go), .addr(addr),
        .reg_rd(reg_rd), .reg_addr(reg_addr));
    vrtct_regs vrtct_regs_i (.clock(clock), .arst_n(arst_n), .reg_addr(reg_addr),
        .reg_rd(reg_rd), .reg_wr(reg_wr), .reg_wdata(reg_wdata), .reg_sel_b(reg_sel_b),
        .reg_rdata(reg_rdata), .thermistor_input_a(therm_a), .thermistor_input_b(therm_b),
        .vr_settled(vr_settled), .icc_alert(icc), .parity_err(err_ev[0]),
        .frame_err(err_ev[1]), .current_limit_strap_a(strap_a),
        .current_limit_strap_b(strap_b), .active_phases_a(ph_a), .active_phases_b(ph_b),
        .slew_rate_strap(slew), .alert_n(alert_n), .hot_output_n(hot_output_n),
        .reg_a_disable(reg_a_disable), .reg_b_disable(reg_b_disable));

    // Byte results
    task automatic cmp_byte(input string what, input logic [7:0] e, input logic [7:0] got);
        comparisons++;
        if (got !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %h seen %h", what, e, got);
        end
    endtask
    // Pin results
    task automatic cmp_pin(input string what, input logic e, input logic got);
        comparisons++;
        if (got !== e) begin
            err_count++;
            $display("CHECK FAILED %s expected %b seen %b", what, e, got);
        end
    endtask
    // Read request; the note goes into the queue before the master launches it
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        exp_q.push_back(e);
        go = 1'b1;
        addr = a;
        @(posedge clock);
        #1;
    endtask
    // Idle cycles; go drops here so back-to-back reads never touch it twice a step
    task automatic tick(input int n);
        go = 1'b0;
        repeat (n) begin
            @(posedge clock);
            #1;
        end
    endtask
    task automatic end_sim();
        $display("comparisons %0d err_count %0d", comparisons, err_count);
        if (err_count == 0 && comparisons > 0)
            $display("Test passed");
        else
            $display("Test failed");
        $finish;
    endtask

    // Read data watcher: a read seen launched is answered one edge after it is taken
    always @(posedge clock) begin
        #1;
        cycles++;
        if (pend) begin
            if (exp_q.size() == 0) begin
                err_count++;
                $display("CHECK FAILED read data expected none seen %h", reg_rdata);
            end else begin
                cmp_byte("read data", exp_q.pop_front(), reg_rdata);
            end
        end
        pend = reg_rd;
        // Whole run needs a few hundred cycles; this bound only cuts a hang
        if (cycles == 3000) begin
            err_count++;
            end_sim();
        end
    end

    initial begin
        void'($urandom(32'h2A29));
        repeat (10) @(posedge clock);
        #1;
        arst_n = 1'b1;
        tick(2);
        cmp_pin("disable a", 1'b0, reg_a_disable);
        // Writes land on the bank while reading, and must change nothing
        reg_wr = 1'b1;
        reg_wdata = 8'($urandom);
        rd(vrtct_pkg::OFS_MAX_TEMPERATURE, vrtct_pkg::MAX_TEMPERATURE_VAL);
        rd(8'h22, 8'h64);
        rd(8'h30, 8'h00);
        rd(8'h1C, 8'h00);
        tick(2);
        reg_wr = 1'b0;
        // Random thermometer codes on both inputs
        for (k = 0; k < 10; k++) begin
            therm_a = 8'hFF >> $urandom_range(8, 0);
            therm_b = (k == 0) ? 8'hFF : 8'hFF >> $urandom_range(8, 0);
            tick(2);
            cmp_pin("hot pin", !(therm_a[7] | therm_b[7]), hot_output_n);
            rd(8'h12, therm_a | therm_b);
            tick(1);
        end
        therm_a = 8'h00;
        therm_b = 8'h00;
        tick(3);
        rd(8'h10, 8'h01);
        tick(3);
        cmp_pin("alert line", 1'b1, alert_n);
        therm_b = 8'h7F;
        tick(4);
        cmp_pin("alert line", 1'b0, alert_n);
        rd(8'h10, 8'h03);
        tick(3);
        // Each error event, its capture and the clear on read
        for (k = 0; k < 2; k++) begin
            err_ev = 2'(1 << k);
            tick(1);
            err_ev = 2'h0;
            tick(2);
            rd(8'h11, 8'(1 << k));
            tick(2);
            rd(8'h1C, 8'(1 << k));
            tick(2);
            rd(8'h11, 8'h00);
            tick(2);
            rd(8'h1C, 8'h00);
            tick(2);
        end
        // Poll releases the line, then an ICC pulse latches bit 2 until the next poll
        rd(8'h10, 8'h03);
        tick(3);
        cmp_pin("alert line", 1'b1, alert_n);
        icc = 1'b1;
        tick(1);
        icc = 1'b0;
        tick(2);
        cmp_pin("alert line", 1'b0, alert_n);
        rd(8'h10, 8'h07);
        tick(3);
        rd(8'h10, 8'h03);
        tick(2);
        // Current-limit straps in the valid range on both regulators
        for (k = 0; k < 8; k++) begin
            lv = $urandom_range(16, 1);
            ph = $urandom_range(3, 1);
            strap_a = lv[4:0];
            strap_b = 5'(17 - lv);
            ph_a = ph[1:0];
            ph_b = 2'(4 - ph);
            reg_sel_b = 1'b0;
            tick(2);
            rd(8'h21, 8'(tbl_a[(lv - 1) % 4] * ph));
            tick(1);
            reg_sel_b = 1'b1;
            rd(8'h21, 8'(tbl_b[(16 - lv) % 4] * (4 - ph)));
            tick(1);
        end
        strap_b = 5'h11;
        tick(2);
        cmp_pin("disable b", 1'b1, reg_b_disable);
        cmp_pin("disable a", 1'b0, reg_a_disable);
        rd(8'h21, 8'h00);
        tick(1);
        strap_a = 5'h00;
        strap_b = 5'h05;
        tick(2);
        cmp_pin("disable a", 1'b1, reg_a_disable);
        cmp_pin("disable b", 1'b1, reg_b_disable);
        // All four slew strap levels
        for (k = 0; k < 4; k++) begin
            slew = k[1:0];
            tick(2);
            rd(8'h24, (k == 1 || k == 2) ? 8'h14 : 8'h0A);
            rd(8'h25, (k == 1 || k == 2) ? 8'h04 : 8'h02);
            tick(2);
        end
        tick(3);
        // Mid-run reset: sticky disables clear and outputs return to idle
        strap_a = 5'h01;
        strap_b = 5'h01;
        arst_n = 1'b0;
        tick(2);
        cmp_pin("disable a", 1'b0, reg_a_disable);
        cmp_pin("disable b", 1'b0, reg_b_disable);
        cmp_pin("hot pin", 1'b1, hot_output_n);
        arst_n = 1'b1;
        tick(3);
        cmp_pin("disable a", 1'b0, reg_a_disable);
        rd(8'h22, 8'h64);
        tick(2);
        end_sim();
    end
endmodule // testbench
`default_nettype wire
